// file: hdl/iicc_pkg.sv
/*
 * Constants, types and state layout for the two-wire controller
 * flag-clear and control register block.
 * Assumes an APB master with 32-bit data and byte addresses.
 */
// Overview of operation
// R1 - Reading the rx-done clear register clears raw status bit 7.
// R2 - Activity clear read only clears when controller is idle; stays set while active.
// R3 - Disabled and bus quiet: hardware clears the activity flag itself.
// R4 - Activity clear read returns the activity flag, raw status bit 8.
// R5 - Reading the stop-seen clear register clears raw status bit 9.
// R6 - Reading the start-seen clear register clears raw status bit 10.
// R7 - Reading the general-call clear register clears raw status bit 11.
// R8 - Control bit 0 enables; while disabled both queues are held erased.
// R9 - Disabling flushes both the transmit and receive queues.
// R10 - After disable, activity state stays asserted until engine reaches idle.
// R11 - Disable during transmit: finish current transfer, then discard transmit contents.
// R12 - Disable during receive: stop at end of byte, do not acknowledge it.
// R13 - Control bit 1 requests master abort; ignored unless enable already set.
// R14 - Software cannot clear abort bit; it reads 1 until abort completes.
// R15 - Abort: finish transfer, issue STOP, flush transmit queue, raise abort event.
// R16 - Control bit 2 blocks transmission; when 0 queued data goes automatically.
// R17 - Block set with empty queue and idle master halts command execution.
// R18 - State register bit 0 shows activity: 1 active, 0 idle.
// R19 - While disabled, transmit-not-full and transmit-empty state bits read 0.
// R20 - Clear registers return flag in bit 0, zeros above; clear on completed read.
// R21 - A flag event coinciding with its clear read wins; flag stays set.
package iicc_pkg;

	// ************************************************************
	// Register map
	// ************************************************************
	localparam logic [7:0] OFF_CLR_RX_DONE = 8'h58;
	localparam logic [7:0] OFF_CLR_ACTIVITY = 8'h5C;
	localparam logic [7:0] OFF_CLR_STOP = 8'h60;
	localparam logic [7:0] OFF_CLR_START = 8'h64;
	localparam logic [7:0] OFF_CLR_GEN_CALL = 8'h68;
	localparam logic [7:0] OFF_CONTROL = 8'h6C;
	localparam logic [7:0] OFF_STATE = 8'h70;

	// ************************************************************
	// Field positions and reset values
	// ************************************************************
	localparam int CTL_ENABLE_BIT = 0;
	localparam int CTL_ABORT_BIT = 1;
	localparam int CTL_TX_BLOCK_BIT = 2;
	localparam int ST_ACTIVE_BIT = 0;
	localparam int ST_TX_NOT_FULL_BIT = 1;
	localparam int ST_TX_EMPTY_BIT = 2;
	localparam int ST_MASTER_BIT = 5;
	localparam int ST_SLAVE_BIT = 6;
	// Flag vector index: raw status bit = RAW_BASE_BIT + index
	localparam int RAW_BASE_BIT = 7;
	localparam int FLAG_COUNT = 5;
	localparam int FLAG_RX_DONE = 0;
	localparam int FLAG_ACTIVITY = 1;
	localparam int FLAG_STOP = 2;
	localparam int FLAG_START = 3;
	localparam int FLAG_GEN_CALL = 4;
	localparam logic [FLAG_COUNT-1:0] FLAGS_RESET = 5'h00;
	localparam logic [31:0] DATA_RESET = 32'h00000000;

	// ************************************************************
	// State machines and state record
	// ************************************************************
	typedef enum logic [1:0] {
		EN_OFF = 2'b00,
		EN_ON = 2'b01,
		EN_DRAIN = 2'b10
	} iicc_en_type;

	typedef enum logic [1:0] {
		AB_IDLE = 2'b00,
		AB_FINISH = 2'b01,
		AB_STOP = 2'b10,
		AB_FLUSH = 2'b11
	} iicc_ab_type;

	typedef struct packed {
		iicc_en_type en_state;
		iicc_ab_type ab_state;
		logic ctl_enable;
		logic tx_block;
		logic [FLAG_COUNT-1:0] flags;
		logic staged;
		logic [31:0] rdata;
	} iicc_state_type;

endpackage

// file: hdl/iicc_ctrl.sv
/*
 * Flag-clear registers, control register and state register of a
 * two-wire serial bus controller, reached over APB.
 * Assumes the shift engine, queues and pins live outside; engine
 * events arrive as one-cycle pulses synchronous to sys_clk_i.
 */
`timescale 1ns/1ps
module iicc_ctrl (
	// Clock, reset, enable
	input logic sys_clk_i,
	input logic rst_i,
	input logic ce_i,
	// APB slave
	input logic psel_i,
	input logic penable_i,
	input logic pwrite_i,
	input logic [7:0] paddr_i,
	input logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Engine events and status
	input logic rx_done_evt_i,
	input logic activity_i,
	input logic stop_seen_evt_i,
	input logic start_seen_evt_i,
	input logic general_call_evt_i,
	input logic master_active_i,
	input logic slave_active_i,
	input logic byte_done_i,
	input logic stop_done_i,
	input logic txq_not_full_i,
	input logic txq_empty_i,
	// Engine controls
	output logic [iicc_pkg::FLAG_COUNT-1:0] raw_flags_o,
	output logic engine_enable_o,
	output logic finish_byte_o,
	output logic rx_nack_o,
	output logic stop_issue_o,
	output logic txq_flush_o,
	output logic rxq_flush_o,
	output logic tx_block_o,
	output logic tx_abort_evt_o,
	output logic abort_busy_o
);
	import iicc_pkg::*;

	iicc_state_type cur;
	iicc_state_type next;
	logic acc_done;
	logic rd_done;
	logic wr_done;
	logic bus_busy;
	logic addr_hit;
	logic [FLAG_COUNT-1:0] flag_evt;
	logic [31:0] state_word;

	// ************************************************************
	// Decode helpers
	// ************************************************************
	// Offset of the clear register for flag index i
	function automatic logic [7:0] clear_offset(input int i);
		logic [7:0] off;
		off = OFF_CLR_RX_DONE + 8'(4 * i);
		return off;
	endfunction

	// Address decodes to one of the mapped words
	function automatic logic is_mapped(input logic [7:0] a);
		logic hit;
		hit = (a >= OFF_CLR_RX_DONE) && (a <= OFF_STATE) && (a[1:0] == 2'h0);
		return hit;
	endfunction

	// ************************************************************
	// Bus handshake and status views
	// ************************************************************
	// Read data is staged in the setup cycle, so access completes with no wait
	assign pready_o = ce_i & cur.staged;
	assign acc_done = psel_i & penable_i & pready_o;
	assign rd_done = acc_done & ~pwrite_i;
	assign wr_done = acc_done & pwrite_i;
	assign addr_hit = is_mapped(paddr_i);
	assign pslverr_o = acc_done & ~addr_hit;
	assign bus_busy = activity_i | master_active_i | slave_active_i;
	assign flag_evt = {general_call_evt_i, start_seen_evt_i, stop_seen_evt_i, activity_i, rx_done_evt_i};

	// State register view; drain keeps activity asserted
	always_comb begin
		state_word = DATA_RESET;
		state_word[ST_ACTIVE_BIT] = bus_busy | (cur.en_state == EN_DRAIN); // R10 R18
		state_word[ST_TX_NOT_FULL_BIT] = cur.ctl_enable & txq_not_full_i; // R19
		state_word[ST_TX_EMPTY_BIT] = cur.ctl_enable & txq_empty_i; // R19
		state_word[ST_MASTER_BIT] = master_active_i;
		state_word[ST_SLAVE_BIT] = slave_active_i;
	end

	// ************************************************************
	// Next-state logic
	// ************************************************************
	always_comb begin
		next = cur;
		if (ce_i) begin
			// Stage read data in setup; captured before any clear lands
			if (acc_done) begin
				next.staged = 1'b0;
			end else if (psel_i && !cur.staged) begin
				next.staged = 1'b1;
				next.rdata = DATA_RESET;
				for (int i = 0; i < FLAG_COUNT; i++) begin
					if (paddr_i == clear_offset(i)) begin
						next.rdata[0] = cur.flags[i]; // R4 R20
					end
				end
				if (paddr_i == OFF_CONTROL) begin
					next.rdata[CTL_ENABLE_BIT] = cur.ctl_enable;
					next.rdata[CTL_ABORT_BIT] = (cur.ab_state != AB_IDLE);
					next.rdata[CTL_TX_BLOCK_BIT] = cur.tx_block;
				end
				if (paddr_i == OFF_STATE) begin
					next.rdata = state_word;
				end
			end

			// Sticky flags; a new event beats a clear in the same cycle
			for (int i = 0; i < FLAG_COUNT; i++) begin
				if (flag_evt[i]) begin
					next.flags[i] = 1'b1; // R21
				end else if (rd_done && paddr_i == clear_offset(i)) begin
					next.flags[i] = 1'b0; // R1 R2 R5 R6 R7 R20
				end
			end
			// Quiet, disabled controller drops its activity flag
			if (cur.en_state == EN_OFF && !bus_busy) begin
				next.flags[FLAG_ACTIVITY] = 1'b0; // R3
			end

			// Control register write
			if (wr_done && paddr_i == OFF_CONTROL) begin
				next.ctl_enable = pwdata_i[CTL_ENABLE_BIT];
				next.tx_block = pwdata_i[CTL_TX_BLOCK_BIT]; // R16
				// Abort only accepted on an already enabled controller
				if (pwdata_i[CTL_ABORT_BIT] && cur.ctl_enable && cur.ab_state == AB_IDLE) begin
					next.ab_state = AB_FINISH; // R13
				end
			end

			// Enable state machine
			case (cur.en_state)
				EN_OFF: begin
					if (next.ctl_enable) begin
						next.en_state = EN_ON;
					end
				end
				EN_ON: begin
					// Busy engine is drained first, so the byte in flight ends cleanly
					if (!next.ctl_enable) begin
						next.en_state = bus_busy ? EN_DRAIN : EN_OFF; // R11 R12
					end
				end
				EN_DRAIN: begin
					if (!master_active_i && !slave_active_i) begin
						next.en_state = EN_OFF; // R10
					end
				end
				default: begin
					next.en_state = EN_OFF;
				end
			endcase

			// Abort state machine; software has no path back to idle
			case (cur.ab_state)
				AB_IDLE: begin
				end
				AB_FINISH: begin
					if (byte_done_i || !master_active_i) begin
						next.ab_state = AB_STOP; // R15
					end
				end
				AB_STOP: begin
					if (stop_done_i) begin
						next.ab_state = AB_FLUSH; // R15
					end
				end
				AB_FLUSH: begin
					next.ab_state = AB_IDLE; // R14
				end
				default: begin
					next.ab_state = AB_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// State register
	// ************************************************************
	// Single flop bank for the whole record; async reset to constants
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cur.en_state <= EN_OFF;
			cur.ab_state <= AB_IDLE;
			cur.ctl_enable <= 1'b0;
			cur.tx_block <= 1'b0;
			cur.flags <= FLAGS_RESET;
			cur.staged <= 1'b0;
			cur.rdata <= DATA_RESET;
		end else begin
			cur <= next;
		end
	end

	// ************************************************************
	// Outputs to the engine
	// ************************************************************
	assign prdata_o = cur.rdata;
	assign raw_flags_o = cur.flags;
	assign engine_enable_o = (cur.en_state == EN_ON);
	// Drain: engine completes current byte, then stops; receiver withholds ack
	assign finish_byte_o = (cur.en_state == EN_DRAIN); // R11 R12
	assign rx_nack_o = (cur.en_state == EN_DRAIN) & slave_active_i; // R12
	assign stop_issue_o = (cur.ab_state == AB_STOP); // R15
	// Queues held erased while off; abort flushes transmit only
	assign txq_flush_o = (cur.en_state == EN_OFF) | (cur.ab_state == AB_FLUSH); // R8 R9 R11 R15
	assign rxq_flush_o = (cur.en_state == EN_OFF); // R8 R9
	// Block holds queued commands; with empty queue the idle master stays idle
	assign tx_block_o = cur.tx_block; // R16 R17
	assign tx_abort_evt_o = (cur.ab_state == AB_FLUSH) & ce_i; // R15
	assign abort_busy_o = (cur.ab_state != AB_IDLE); // R14

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_clear_read(logic [7:0] off);
		ce_i && rd_done && paddr_i == off;
	endsequence

	sequence s_setup_read(logic [7:0] off);
		ce_i && psel_i && !penable_i && !pwrite_i && !cur.staged && paddr_i == off;
	endsequence

	sequence s_ctl_write;
		ce_i && wr_done && paddr_i == OFF_CONTROL;
	endsequence

	AST_RX_CLEAR: assert property (s_clear_read(OFF_CLR_RX_DONE) ##0 !rx_done_evt_i |=> !raw_flags_o[FLAG_RX_DONE]) // R1
		else $error("rx-done flag not cleared by read");
	AST_ACT_HOLD: assert property (s_clear_read(OFF_CLR_ACTIVITY) ##0 activity_i |=> raw_flags_o[FLAG_ACTIVITY]) // R2
		else $error("activity flag cleared while active");
	AST_ACT_AUTO: assert property (ce_i && cur.en_state == EN_OFF && !bus_busy |=> !raw_flags_o[FLAG_ACTIVITY]) // R3
		else $error("activity flag not auto cleared");
	AST_ACT_READ: assert property (s_setup_read(OFF_CLR_ACTIVITY) ##1 (psel_i && penable_i)
		|-> prdata_o == {31'h00000000, $past(raw_flags_o[FLAG_ACTIVITY])}) // R4
		else $error("activity clear read returned wrong value");
	AST_STOP_CLEAR: assert property (s_clear_read(OFF_CLR_STOP) ##0 !stop_seen_evt_i |=> !raw_flags_o[FLAG_STOP]) // R5
		else $error("stop flag not cleared by read");
	AST_START_CLEAR: assert property (s_clear_read(OFF_CLR_START) ##0 !start_seen_evt_i |=> !raw_flags_o[FLAG_START]) // R6
		else $error("start flag not cleared by read");
	AST_GC_CLEAR: assert property (s_clear_read(OFF_CLR_GEN_CALL) ##0 !general_call_evt_i
		|=> !raw_flags_o[FLAG_GEN_CALL]) // R7
		else $error("general-call flag not cleared by read");
	AST_OFF_FLUSH: assert property (!engine_enable_o && !finish_byte_o |-> txq_flush_o && rxq_flush_o) // R8
		else $error("queues not held erased while off");
	AST_DRAIN_ACTIVE: assert property (finish_byte_o |-> state_word[ST_ACTIVE_BIT]) // R10
		else $error("activity dropped during drain");
	AST_ABORT_IGNORED: assert property (wr_done && ce_i && paddr_i == OFF_CONTROL && !cur.ctl_enable
		&& !abort_busy_o |=> !abort_busy_o) // R13
		else $error("abort accepted while disabled");
	AST_ABORT_STICKY: assert property (abort_busy_o && cur.ab_state != AB_FLUSH |=> abort_busy_o) // R14
		else $error("abort bit dropped before completion");
	AST_ABORT_END: assert property (ce_i && stop_issue_o && stop_done_i |=> txq_flush_o && tx_abort_evt_o
		##1 !abort_busy_o) // R15
		else $error("abort did not flush and signal");
	AST_TX_OFF_ZERO: assert property (!cur.ctl_enable |-> !state_word[ST_TX_NOT_FULL_BIT]
		&& !state_word[ST_TX_EMPTY_BIT]) // R19
		else $error("transmit state bits not forced low");
	AST_EVENT_WINS: assert property (s_clear_read(OFF_CLR_RX_DONE) ##0 rx_done_evt_i |=> raw_flags_o[FLAG_RX_DONE]) // R21
		else $error("event lost against clear read");

	// ************************************************************
	// Event capture and read-back shape
	// ************************************************************
	// Every event must land in its flag on the next edge
	AST_RX_SET: assert property (ce_i && rx_done_evt_i |=> raw_flags_o[FLAG_RX_DONE]) // R1
		else $error("rx-done event not captured");
	AST_STOP_SET: assert property (ce_i && stop_seen_evt_i |=> raw_flags_o[FLAG_STOP]) // R5
		else $error("stop event not captured");
	AST_START_SET: assert property (ce_i && start_seen_evt_i |=> raw_flags_o[FLAG_START]) // R6
		else $error("start event not captured");
	AST_GC_SET: assert property (ce_i && general_call_evt_i |=> raw_flags_o[FLAG_GEN_CALL]) // R7
		else $error("general-call event not captured");
	// Writes to a clear register have no side effect
	AST_NO_WRITE_CLEAR: assert property (ce_i && wr_done && paddr_i == OFF_CLR_RX_DONE
		&& raw_flags_o[FLAG_RX_DONE] |=> raw_flags_o[FLAG_RX_DONE]) // R20
		else $error("write to clear register cleared a flag");
	// Upper bits of every clear register read as zero
	AST_CLEAR_ZERO: assert property (ce_i && psel_i && penable_i && !pwrite_i && paddr_i >= OFF_CLR_RX_DONE
		&& paddr_i <= OFF_CLR_GEN_CALL |-> prdata_o[31:1] == 31'h00000000) // R20
		else $error("clear register upper bits not zero");
	// State register read returns the view as it stood at setup
	AST_STATE_READ: assert property (s_setup_read(OFF_STATE) |=> prdata_o == $past(state_word)) // R18 R19
		else $error("state register read mismatch");

	// ************************************************************
	// Enable, drain and flush
	// ************************************************************
	// Enabling releases both queues on the next edge
	AST_ENABLE_ON: assert property (s_ctl_write ##0 pwdata_i[CTL_ENABLE_BIT] && !finish_byte_o
		|=> engine_enable_o && !txq_flush_o && !rxq_flush_o) // R8
		else $error("enable did not release queues");
	// Quiet disable flushes at once
	AST_DISABLE_FLUSH: assert property (s_ctl_write ##0 !pwdata_i[CTL_ENABLE_BIT] && engine_enable_o && !bus_busy
		|=> txq_flush_o && rxq_flush_o) // R9
		else $error("quiet disable did not flush");
	// Busy disable drains first
	AST_DISABLE_DRAIN: assert property (s_ctl_write ##0 !pwdata_i[CTL_ENABLE_BIT] && engine_enable_o && bus_busy
		|=> finish_byte_o && !txq_flush_o) // R11
		else $error("busy disable did not drain");
	AST_DRAIN_HOLD: assert property (finish_byte_o && (master_active_i || slave_active_i) |=> finish_byte_o) // R11
		else $error("drain left while engine busy");
	AST_DRAIN_NO_RUN: assert property (finish_byte_o |-> !engine_enable_o) // R11
		else $error("engine enabled during drain");
	AST_DRAIN_END: assert property (ce_i && finish_byte_o && !master_active_i && !slave_active_i
		|=> !finish_byte_o && txq_flush_o && rxq_flush_o) // R9 R10
		else $error("drain did not end in flush");
	// Byte in flight is never acknowledged while draining with the slave active; rx_nack_o stays low for a master
	AST_NACK_SLAVE: assert property (finish_byte_o && slave_active_i |-> rx_nack_o) // R12
		else $error("receiver not refusing ack in drain");
	AST_NACK_ONLY_DRAIN: assert property (rx_nack_o |-> finish_byte_o) // R12
		else $error("ack refused outside drain");

	// ************************************************************
	// Transmit block and abort
	// ************************************************************
	AST_BLOCK_SET: assert property (s_ctl_write ##0 pwdata_i[CTL_TX_BLOCK_BIT] |=> tx_block_o) // R16 R17
		else $error("transmit block not set");
	AST_BLOCK_CLR: assert property (s_ctl_write ##0 !pwdata_i[CTL_TX_BLOCK_BIT] |=> !tx_block_o) // R16
		else $error("transmit block not cleared");
	// Only a control write may move the block bit
	AST_BLOCK_HOLD: assert property (!(ce_i && wr_done && paddr_i == OFF_CONTROL) |=> $stable(tx_block_o)) // R17
		else $error("transmit block changed without write");
	AST_ABORT_STOP: assert property (ce_i && cur.ab_state == AB_FINISH && byte_done_i |=> stop_issue_o) // R15
		else $error("abort did not ask for STOP");
	AST_STOP_HOLD: assert property (ce_i && stop_issue_o && !stop_done_i |=> stop_issue_o) // R15
		else $error("STOP request dropped early");
	AST_ABORT_PULSE: assert property (tx_abort_evt_o |=> !tx_abort_evt_o) // R15
		else $error("abort event longer than one cycle");
	AST_ABORT_READ: assert property (s_setup_read(OFF_CONTROL) ##0 abort_busy_o |=> prdata_o[CTL_ABORT_BIT]) // R14
		else $error("abort bit not read back as busy");

endmodule

// file: verif/iicc_engine_model.sv
/*
 * Stand-in for the shift engine next to the control block: one transfer
 * per start pulse, finish and STOP requests answered after fixed delays.
 * Assumes its inputs change just after rising edges of clk_i.
 */
`timescale 1ns/1ps
module iicc_engine_model #(
	parameter int BYTE_CYCLES = 20,
	parameter int STOP_CYCLES = 8
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Requests from bench and block
	input wire logic start_i,
	input wire logic finish_i,
	input wire logic stop_req_i,
	// Answers to the block
	output logic master_active_o,
	output logic byte_done_o,
	output logic stop_done_o
);
	int byte_cnt;
	int stop_cnt;

	// Slow answers on purpose, so that the block must wait for them
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			master_active_o <= 1'b0;
			byte_done_o <= 1'b0;
			stop_done_o <= 1'b0;
			byte_cnt <= 0;
			stop_cnt <= 0;
		end else begin
			byte_done_o <= 1'b0;
			stop_done_o <= 1'b0;
			if (start_i) begin
				master_active_o <= 1'b1;
				byte_cnt <= 0;
			end else if (master_active_o && finish_i) begin
				byte_cnt <= byte_cnt + 1;
				if (byte_cnt == BYTE_CYCLES) begin
					master_active_o <= 1'b0;
					byte_done_o <= 1'b1;
				end
			end
			// Guard on the pulse: the request falls one cycle after it
			if (stop_req_i && !stop_done_o) begin
				stop_cnt <= stop_cnt + 1;
				if (stop_cnt == STOP_CYCLES) begin
					stop_done_o <= 1'b1;
					stop_cnt <= 0;
				end
			end else begin
				stop_cnt <= 0;
			end
		end
	end
endmodule

// file: verif/iicc_ctrl_bench.sv
/*
 * Directed bench of the flag-clear and control block over APB.
 * Assumes the package, the block and the engine model are compiled first.
 */
`timescale 1ns/1ps
module iicc_ctrl_bench;
	import iicc_pkg::*;
	logic sys_clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, er, act = 1'b0, slv = 1'b0, start = 1'b0;
	logic [3:0] evt = 4'h0, hit = 4'h0;
	logic mst, bdone, sdone, finb, nack, stp, txf, rxf, tblk, abev, abb, en, seen;
	logic [FLAG_COUNT-1:0] flags;
	logic [7:0] clr_addr [4] = '{OFF_CLR_RX_DONE, OFF_CLR_STOP, OFF_CLR_START, OFF_CLR_GEN_CALL};
	int bad_count = 0, checks = 0, n;

	iicc_ctrl dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(ce_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .rx_done_evt_i(evt[0]), .activity_i(act), .stop_seen_evt_i(evt[1]),
		.start_seen_evt_i(evt[2]), .general_call_evt_i(evt[3]), .master_active_i(mst),
		.slave_active_i(slv), .byte_done_i(bdone), .stop_done_i(sdone), .txq_not_full_i(1'b1),
		.txq_empty_i(1'b1), .raw_flags_o(flags), .engine_enable_o(en), .finish_byte_o(finb),
		.rx_nack_o(nack), .stop_issue_o(stp), .txq_flush_o(txf), .rxq_flush_o(rxf),
		.tx_block_o(tblk), .tx_abort_evt_o(abev), .abort_busy_o(abb));
	iicc_engine_model model (.clk_i(sys_clk_i), .rst_i(rst_i), .start_i(start), .finish_i(finb | abb),
		.stop_req_i(stp), .master_active_o(mst), .byte_done_o(bdone), .stop_done_o(sdone));

	// Free-running clock, 4 ns period
	initial forever #2 sys_clk_i = ~sys_clk_i;

	task chk(input logic [32:0] got, input logic [32:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h, want %h", $time, got, exp);
		end
	endtask

	// One APB transfer; signals move just after rising edges, answer taken at the edge with pready high
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk_i);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge sys_clk_i);
		penable <= 1'b1;
		evt <= hit;
		n = 0;
		do begin
			@(posedge sys_clk_i);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		evt <= 4'h0;
		psel <= 1'b0;
		penable <= 1'b0;
		chk(n < 50, 1'b1);
	endtask

	task pulse(input logic [3:0] m);
		@(posedge sys_clk_i);
		evt <= m;
		@(posedge sys_clk_i);
		evt <= 4'h0;
		repeat (2) @(negedge sys_clk_i);
	endtask

	// Settled sampling point some cycles ahead
	task settle(input int c);
		repeat (c) @(negedge sys_clk_i);
	endtask

	task t_reset;
		chk(flags, 5'h00);
		chk(txf & rxf, 1'b1);
		apb(OFF_STATE, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(8'h10, 1'b0, 32'h0);
		chk({er, rd}, 33'h100000000);
	endtask

	task t_flags;
		for (int i = 0; i < 4; i++) begin
			pulse(4'h1 << i);
			apb(clr_addr[i], 1'b0, 32'h0);
			chk(rd, 32'h1);
			settle(1);
			chk(flags, 5'h00);
			apb(clr_addr[i], 1'b0, 32'h0);
			chk(rd, 32'h0);
		end
		hit = 4'h1;
		apb(OFF_CLR_RX_DONE, 1'b0, 32'h0);
		hit = 4'h0;
		settle(1);
		chk(flags[FLAG_RX_DONE], 1'b1);
	endtask

	task t_enable;
		apb(OFF_CONTROL, 1'b1, 32'h1);
		settle(2);
		chk({en, txf, rxf}, 3'b100);
		apb(OFF_STATE, 1'b0, 32'h0);
		chk(rd, 32'h6);
		act <= 1'b1;
		apb(OFF_CLR_ACTIVITY, 1'b0, 32'h0);
		chk(rd, 32'h1);
		chk(flags[FLAG_ACTIVITY], 1'b1);
		act <= 1'b0;
		apb(OFF_CLR_ACTIVITY, 1'b0, 32'h0);
		settle(1);
		chk({rd[0], flags[FLAG_ACTIVITY]}, 2'b10);
		act <= 1'b1;
		start <= 1'b1;
		slv <= 1'b1;
		apb(OFF_CONTROL, 1'b1, 32'h0);
		start <= 1'b0;
		settle(2);
		chk({finb, nack, txf, rxf}, 4'b1100);
		apb(OFF_STATE, 1'b0, 32'h0);
		chk(rd[ST_ACTIVE_BIT], 1'b1);
		slv <= 1'b0;
		act <= 1'b0;
		for (n = 0; n < 100 && txf !== 1'b1; n++) @(negedge sys_clk_i);
		chk({en, finb, txf, rxf, mst}, 5'b00110);
		settle(1);
		chk(flags[FLAG_ACTIVITY], 1'b0);
	endtask

	task t_abort;
		apb(OFF_CONTROL, 1'b1, 32'h2);
		apb(OFF_CONTROL, 1'b0, 32'h0);
		chk(rd, 32'h0);
		apb(OFF_CONTROL, 1'b1, 32'h1);
		start <= 1'b1;
		apb(OFF_CONTROL, 1'b1, 32'h3);
		start <= 1'b0;
		apb(OFF_CONTROL, 1'b1, 32'h1);
		apb(OFF_CONTROL, 1'b0, 32'h0);
		chk({rd, abb}, 33'h7);
		seen = 1'b0;
		for (n = 0; n < 200 && abev !== 1'b1; n++) begin
			@(negedge sys_clk_i);
			seen = seen | stp;
		end
		chk({seen, txf, mst}, 3'b110);
		settle(2);
		chk({abb, abev}, 2'b00);
	endtask

	task t_block;
		apb(OFF_CONTROL, 1'b1, 32'h5);
		settle(1);
		chk(tblk, 1'b1);
		apb(OFF_CONTROL, 1'b1, 32'h1);
		settle(1);
		chk(tblk, 1'b0);
	endtask

	task finish_test;
		$display("mismatches %0d, comparisons %0d", bad_count, checks);
		if (bad_count == 0 && checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// Whole run is about 150 cycles
	initial begin
		#100000;
		bad_count++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge sys_clk_i);
		rst_i <= 1'b0;
		settle(1);
		t_reset();
		t_flags();
		t_enable();
		t_abort();
		t_block();
		finish_test();
	end
endmodule
